// ### verilog/lcd_host_interface_front_end.sv
// Overview of operation
// - decode mode pins into bus widths and serial
// - low reset pin resets everything but frame memory
// - transfers accepted only while chip select low
// - select high means data, low means command
// - read strobe controls parallel reads
// - write strobe, or serial clock in serial
// - upper bus lines drive sub panel in MDDI
// - serial bits taken from serial input pin
// - serial read data returned on output pin
// - tear sync enabled by software, else low
// - syncs become sub panel outputs in MDDI
// - backlight PWM width in 255 steps
// - separate backlight on/off output
// - common electrode alternation period and enable
// - frame memory holds full 240x432 image
// - host writes only update the defined window
// - reduced color keeps component MSBs only
// - seven bit trim for common electrode level
// - parallel writes captured on strobe rising edge
// - first memory read is a dummy
// - address counter steps by one per pixel
// - select low during read leaves bus released
`timescale 1ns/1ps
module lcd_host_interface_front_end (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  // host pins
  input  wire logic [2:0]                   iface_mode_pins_i,
  input  wire logic                         chip_sel_n_i,
  input  wire logic                         data_cmd_sel_i,
  input  wire logic                         read_strobe_n_i,
  input  wire logic                         write_strobe_n_i,
  input  wire logic [17:0]                  parallel_bus_i,
  output logic      [17:0]                  parallel_bus_o,
  output logic      [17:0]                  parallel_bus_oe_o,
  input  wire logic                         serial_in_i,
  output logic                              serial_out_o,
  // video pins
  input  wire logic                         pixel_clk_i,
  input  wire logic                         vsync_i,
  output logic                              vsync_o,
  output logic                              vsync_oe_o,
  input  wire logic                         hsync_i,
  output logic                              sub_panel_regsel_o,
  output logic                              hsync_oe_o,
  input  wire logic                         pixel_valid_i,
  output logic                              pixel_valid_o,
  output logic                              pixel_valid_oe_o,
  // panel side pins
  output logic                              tear_sync_out_o,
  output logic                              backlight_pwm_o,
  output logic                              backlight_enable_out_o,
  output logic                              vcom_polarity_o,
  output logic      [6:0]                   vcom_trim_o,
  // command stream
  output logic                              cmd_valid_o,
  output logic                              param_valid_o,
  output logic      [7:0]                   xfer_byte_o,
  input  wire logic [7:0]                   param_rd_i,
  output logic      [2:0]                   active_mode_o,
  // control
  input  wire logic                         ram_write_mode_i,
  input  wire logic                         ram_read_mode_i,
  input  wire logic                         addr_set_i,
  input  wire lcd_front_pkg::window_t       win_i,
  input  wire logic                         addr_step_down_i,
  input  wire logic                         video_mode_i,
  input  wire logic                         tear_enable_i,
  input  wire logic                         frame_blank_i,
  input  wire logic [7:0]                   pwm_duty_i,
  input  wire logic                         backlight_on_i,
  input  wire logic [7:0]                   vcom_period_i,
  input  wire logic                         vcom_run_i,
  input  wire logic                         trim_prog_i,
  input  wire logic [6:0]                   trim_data_i,
  input  wire logic                         reduced_color_i,
  // display scan
  input  wire logic [16:0]                  disp_addr_i,
  output logic      [17:0]                  disp_pixel_o,
  // sub panel source
  input  wire logic                         sub_cs_n_i,
  input  wire logic                         sub_regsel_i,
  input  wire logic                         sub_wr_n_i,
  input  wire logic [8:0]                   sub_bus_i
);

  // ********
  // pin synchronisers
  // ********
  lcd_front_pkg::pin_in_t raw_w, meta_q, pin_q, prev_q;

  assign raw_w = '{chip_sel_n: chip_sel_n_i, data_cmd_sel: data_cmd_sel_i,
                   read_strobe_n: read_strobe_n_i, write_strobe_n: write_strobe_n_i,
                   serial_in: serial_in_i, pixel_clk: pixel_clk_i, vsync: vsync_i,
                   hsync: hsync_i, pixel_valid: pixel_valid_i,
                   bus: parallel_bus_i, mode: iface_mode_pins_i};

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= '1;
      pin_q  <= '1;
      prev_q <= '1;
    end
    else
    begin
      meta_q <= raw_w;
      pin_q  <= meta_q;
      prev_q <= pin_q;
    end
  end

  // ********
  // mode capture
  // ********
  lcd_front_pkg::iface_mode_t mode_q;
  logic                       mode_ok_q;
  logic [1:0]                 mode_wait_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_q    <= lcd_front_pkg::MODE_PAR18;
      mode_ok_q <= 1'b0;
      mode_wait_q <= 2'b00;
    end
    else if (!mode_ok_q)
    begin
      mode_wait_q <= {mode_wait_q[0], 1'b1};
      mode_q    <= lcd_front_pkg::iface_mode_t'(pin_q.mode);
      mode_ok_q <= mode_wait_q[1];
    end
  end

  wire is_mddi  = mode_ok_q && (mode_q == lcd_front_pkg::MODE_MDDI);
  wire is_ser   = mode_ok_q && ((mode_q == lcd_front_pkg::MODE_SER9) ||
                                (mode_q == lcd_front_pkg::MODE_SER8));
  wire is_par   = mode_ok_q && !is_mddi && !is_ser;
  wire is_wide  = (mode_q == lcd_front_pkg::MODE_PAR18) || (mode_q == lcd_front_pkg::MODE_PAR16);
  wire two_beat = (mode_q == lcd_front_pkg::MODE_PAR9) || (mode_q == lcd_front_pkg::MODE_CPU9);
  wire selected = !pin_q.chip_sel_n;
  wire wr_rise  = pin_q.write_strobe_n && !prev_q.write_strobe_n;
  wire wr_fall  = !pin_q.write_strobe_n && prev_q.write_strobe_n;
  wire rd_fall  = !pin_q.read_strobe_n && prev_q.read_strobe_n;
  wire rd_rise  = pin_q.read_strobe_n && !prev_q.read_strobe_n;
  wire pclk_up  = pin_q.pixel_clk && !prev_q.pixel_clk;
  wire cs_rise  = pin_q.chip_sel_n && !prev_q.chip_sel_n;
  assign active_mode_o = mode_q;

  // ********
  // serial receive
  // ********
  logic [8:0] sr_q;
  logic [3:0] bits_q;
  wire        ser9     = (mode_q == lcd_front_pkg::MODE_SER9);
  wire  [3:0] ser_len  = ser9 ? 4'd9 : 4'd8;
  wire        ser_bit  = is_ser && selected && wr_rise;
  wire        ser_done = ser_bit && (bits_q == ser_len - 4'd1);
  wire  [8:0] ser_word = {sr_q[7:0], pin_q.serial_in};

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sr_q   <= 9'h000;
      bits_q <= 4'h0;
    end
    else if (!selected)
    begin
      bits_q <= 4'h0;
    end
    else if (ser_bit)
    begin
      sr_q   <= ser_word;
      bits_q <= ser_done ? 4'h0 : bits_q + 4'h1;
    end
  end

  // ********
  // transfer capture
  // ********
  wire par_wr = is_par && selected && wr_rise && !video_mode_i;
  lcd_front_pkg::host_xfer_t xfer_w;
  assign xfer_w.dcx  = is_ser ? (ser9 ? ser_word[8] : pin_q.data_cmd_sel)
                              : pin_q.data_cmd_sel;
  assign xfer_w.data = is_ser ? {10'h000, ser_word[7:0]} : pin_q.bus;
  wire xfer_go  = par_wr || ser_done;
  wire is_cmd   = xfer_go && !xfer_w.dcx;
  wire is_data  = xfer_go && xfer_w.dcx;

  // ********
  // pixel assembly
  // ********
  logic [1:0]  beat_q;
  logic [17:0] acc_q;
  wire  [1:0]  beats   = is_wide ? 2'd1 : (two_beat ? 2'd2 : 2'd3);
  wire  [15:0] d16     = xfer_w.data[15:0];
  wire  [17:0] d565    = {d16[15:11], d16[15], d16[10:5], d16[4:0], d16[4]};
  wire  [17:0] d_beat  = two_beat ? {acc_q[8:0], xfer_w.data[8:0]}
                                  : {acc_q[11:0], xfer_w.data[7:2]};
  wire  [17:0] pix_in  = (mode_q == lcd_front_pkg::MODE_PAR16) ? d565
                       : (mode_q == lcd_front_pkg::MODE_PAR18) ? xfer_w.data : d_beat;
  wire         pix_end = is_data && ram_write_mode_i && (beat_q == beats - 2'd1);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      beat_q <= 2'd0;
      acc_q  <= lcd_front_pkg::PIX_RST;
    end
    else if (is_cmd)
    begin
      beat_q <= 2'd0;
    end
    else if (is_data && ram_write_mode_i)
    begin
      acc_q  <= d_beat;
      beat_q <= pix_end ? 2'd0 : beat_q + 2'd1;
    end
  end

  // ********
  // address counter and window
  // ********
  logic [7:0] x_q;
  logic [8:0] y_q;
  logic [16:0] vid_addr_q;
  logic        rd_go;
  wire  step    = pix_end || rd_go;
  wire  x_edge  = addr_step_down_i ? (x_q == win_i.x_start) : (x_q == win_i.x_end);
  wire  y_edge  = addr_step_down_i ? (y_q == win_i.y_start) : (y_q == win_i.y_end);
  wire  [7:0] x_wrap = addr_step_down_i ? win_i.x_end : win_i.x_start;
  wire  [8:0] y_wrap = addr_step_down_i ? win_i.y_end : win_i.y_start;
  wire  [7:0] x_step = addr_step_down_i ? x_q - 8'd1 : x_q + 8'd1;
  wire  [8:0] y_step = addr_step_down_i ? y_q - 9'd1 : y_q + 9'd1;
  wire  [16:0] host_addr = 17'(y_q) * 17'(lcd_front_pkg::COLS) + {9'h000, x_q};

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      x_q <= 8'h00;
      y_q <= 9'h000;
    end
    else if (addr_set_i)
    begin
      x_q <= addr_step_down_i ? win_i.x_end : win_i.x_start;
      y_q <= addr_step_down_i ? win_i.y_end : win_i.y_start;
    end
    else if (step)
    begin
      x_q <= x_edge ? x_wrap : x_step;
      y_q <= x_edge ? (y_edge ? y_wrap : y_step) : y_q;
    end
  end

  // ********
  // video input path
  // ********
  wire vid_on  = video_mode_i && !is_mddi && !is_ser && mode_ok_q;
  wire vid_wr  = vid_on && pclk_up && pin_q.pixel_valid;
  wire vid_top = vid_on && !pin_q.vsync;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vid_addr_q <= 17'h00000;
    end
    else if (vid_top)
    begin
      vid_addr_q <= 17'h00000;
    end
    else if (vid_wr)
    begin
      vid_addr_q <= (vid_addr_q == 17'(lcd_front_pkg::MEM_WORDS - 1)) ? 17'h00000
                                                                       : vid_addr_q + 17'd1;
    end
  end

  // ********
  // frame memory
  // ********
  logic [17:0] mem_rd_w;
  logic [17:0] disp_raw_w;
  wire         mem_we    = pix_end || vid_wr;
  wire  [16:0] mem_waddr = vid_wr ? vid_addr_q : host_addr;
  wire  [17:0] mem_wdata = vid_wr ? pin_q.bus : pix_in;

  frame_memory_ram u_mem (
    .clk_i     (clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .raddr_a_i (host_addr),
    .rdata_a_o (mem_rd_w),
    .raddr_b_i (disp_addr_i),
    .rdata_b_o (disp_raw_w)
  );

  assign disp_pixel_o = reduced_color_i ? {{6{disp_raw_w[17]}}, {6{disp_raw_w[11]}},
                                           {6{disp_raw_w[5]}}} : disp_raw_w;

  // ********
  // parallel read
  // ********
  logic [17:0] rd_hold_q;
  logic        rd_fill_q;
  logic        rd_drive_q;
  wire         rd_ok = is_par && selected && pin_q.data_cmd_sel;
  assign rd_go = rd_ok && rd_fall && ram_read_mode_i;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_hold_q      <= lcd_front_pkg::PIX_RST;
      rd_fill_q      <= 1'b0;
      rd_drive_q     <= 1'b0;
      parallel_bus_o <= 18'h00000;
    end
    else
    begin
      rd_fill_q <= rd_go;
      if (rd_fill_q)
      begin
        rd_hold_q <= mem_rd_w;
      end
      if (rd_ok && rd_fall)
      begin
        parallel_bus_o <= ram_read_mode_i ? rd_hold_q : {10'h000, param_rd_i};
        rd_drive_q     <= 1'b1;
      end
      else if (rd_rise || !rd_ok)
      begin
        rd_drive_q <= 1'b0;
      end
      if (is_mddi)
      begin
        parallel_bus_o[17:9] <= sub_bus_i;
      end
    end
  end

  assign parallel_bus_oe_o[8:0]  = {9{rd_drive_q}};
  assign parallel_bus_oe_o[17:9] = {9{is_mddi || (rd_drive_q && is_wide)}};

  // ********
  // serial read
  // ********
  logic [7:0] tx_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_q <= 8'h00;
    end
    else if (!is_ser || cs_rise)
    begin
      tx_q <= 8'h00;
    end
    else if (is_cmd)
    begin
      tx_q <= param_rd_i;
    end
    else if (selected && wr_fall && bits_q != 4'h0)
    begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign serial_out_o = tx_q[7];

  // ********
  // sub panel, stream and misc outputs
  // ********
  logic [15:0] alt_div_q;
  logic [7:0]  alt_cnt_q;
  logic [6:0]  trim_q;
  logic        trim_done_q;
  wire         alt_tick = (alt_div_q == 16'(lcd_front_pkg::ALT_STEP_CYC - 1));

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vsync_o                <= 1'b1;
      sub_panel_regsel_o     <= 1'b0;
      pixel_valid_o          <= 1'b1;
      cmd_valid_o            <= 1'b0;
      param_valid_o          <= 1'b0;
      xfer_byte_o            <= 8'h00;
      tear_sync_out_o        <= 1'b0;
      backlight_enable_out_o <= 1'b0;
      alt_div_q              <= 16'h0000;
      alt_cnt_q              <= 8'h00;
      vcom_polarity_o        <= 1'b0;
      trim_q                 <= lcd_front_pkg::TRIM_RST;
      trim_done_q            <= 1'b0;
    end
    else
    begin
      vsync_o                <= sub_cs_n_i;
      sub_panel_regsel_o     <= sub_regsel_i;
      pixel_valid_o          <= sub_wr_n_i;
      cmd_valid_o            <= is_cmd;
      param_valid_o          <= is_data && !ram_write_mode_i;
      xfer_byte_o            <= xfer_go ? xfer_w.data[7:0] : xfer_byte_o;
      tear_sync_out_o        <= tear_enable_i && frame_blank_i;
      backlight_enable_out_o <= backlight_on_i;
      alt_div_q              <= alt_tick ? 16'h0000 : alt_div_q + 16'h0001;
      if (!vcom_run_i)
      begin
        alt_cnt_q <= 8'h00;
      end
      else if (alt_tick)
      begin
        alt_cnt_q       <= (alt_cnt_q == vcom_period_i) ? 8'h00 : alt_cnt_q + 8'h01;
        vcom_polarity_o <= (alt_cnt_q == vcom_period_i) ? !vcom_polarity_o : vcom_polarity_o;
      end
      if (trim_prog_i && !trim_done_q)
      begin
        trim_q      <= trim_data_i;
        trim_done_q <= 1'b1;
      end
    end
  end

  assign vcom_trim_o      = trim_q;
  assign vsync_oe_o       = is_mddi;
  assign hsync_oe_o       = is_mddi;
  assign pixel_valid_oe_o = is_mddi;

  backlight_pwm_gen u_pwm (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .duty_i    (pwm_duty_i),
    .pwm_o     (backlight_pwm_o)
  );

endmodule

// ### verilog/lcd_front_pkg.sv
package lcd_front_pkg;

  // ********
  // clock and timing
  // ********
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned CLK_PERIOD_NS  = 1000000000 / CLK_HZ;
  localparam int unsigned PWM_STEP_NS    = 1000;
  localparam int unsigned PWM_STEP_CYC   = (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ALT_STEP_NS    = 20000;
  localparam int unsigned ALT_STEP_CYC   = (ALT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********
  // frame memory geometry
  // ********
  localparam int unsigned COLS      = 240;
  localparam int unsigned ROWS      = 432;
  localparam int unsigned MEM_BYTES = 233280;
  localparam int unsigned MEM_WORDS = COLS * ROWS;
  localparam int unsigned PIX_W     = 18;
  localparam int unsigned ADDR_W    = 17;
  localparam int unsigned X_W       = 8;
  localparam int unsigned Y_W       = 9;
  localparam int unsigned BUS_W     = 18;
  localparam int unsigned SUB_LSB   = 9;

  // ********
  // reset values
  // ********
  localparam logic [6:0]  TRIM_RST  = 7'h00;
  localparam logic [17:0] PIX_RST   = 18'h00000;

  // ********
  // interface modes
  // ********
  typedef enum logic [2:0] {
    MODE_PAR18  = 3'b000,
    MODE_PAR9   = 3'b001,
    MODE_PAR16  = 3'b010,
    MODE_PAR8   = 3'b011,
    MODE_MDDI   = 3'b100,
    MODE_SER9   = 3'b101,
    MODE_CPU9   = 3'b110,
    MODE_SER8   = 3'b111
  } iface_mode_t;

  // ********
  // carriers
  // ********
  typedef struct packed {
    logic             chip_sel_n;
    logic             data_cmd_sel;
    logic             read_strobe_n;
    logic             write_strobe_n;
    logic             serial_in;
    logic             pixel_clk;
    logic             vsync;
    logic             hsync;
    logic             pixel_valid;
    logic [BUS_W-1:0] bus;
    logic [2:0]       mode;
  } pin_in_t;

  typedef struct packed {
    logic [X_W-1:0] x_start;
    logic [X_W-1:0] x_end;
    logic [Y_W-1:0] y_start;
    logic [Y_W-1:0] y_end;
  } window_t;

  typedef struct packed {
    logic             dcx;
    logic [BUS_W-1:0] data;
  } host_xfer_t;

endpackage

// ### verilog/frame_memory_ram.sv
`timescale 1ns/1ps
module frame_memory_ram (
  // clock
  input  wire logic                                clk_i,
  // write port
  input  wire logic                                we_i,
  input  wire logic [lcd_front_pkg::ADDR_W-1:0]    waddr_i,
  input  wire logic [lcd_front_pkg::PIX_W-1:0]     wdata_i,
  // read ports, registered
  input  wire logic [lcd_front_pkg::ADDR_W-1:0]    raddr_a_i,
  output logic      [lcd_front_pkg::PIX_W-1:0]     rdata_a_o,
  input  wire logic [lcd_front_pkg::ADDR_W-1:0]    raddr_b_i,
  output logic      [lcd_front_pkg::PIX_W-1:0]     rdata_b_o
);

  logic [lcd_front_pkg::PIX_W-1:0] mem [lcd_front_pkg::MEM_WORDS];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
  end

endmodule

// ### verilog/backlight_pwm_gen.sv
`timescale 1ns/1ps
module backlight_pwm_gen (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic [7:0] duty_i,
  // output
  output logic            pwm_o
);

  localparam logic [7:0] LAST_STEP = 8'hfe;
  localparam int unsigned DIV_MAX  = lcd_front_pkg::PWM_STEP_CYC - 1;

  logic [15:0] div_q;
  logic [7:0]  step_q;
  wire         tick = (div_q == DIV_MAX[15:0]);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_q  <= 16'h0000;
      step_q <= 8'h00;
      pwm_o  <= 1'b0;
    end
    else
    begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      if (tick)
      begin
        step_q <= (step_q == LAST_STEP) ? 8'h00 : step_q + 8'h01;
      end
      pwm_o <= (step_q < duty_i);
    end
  end

endmodule

// ### verif/lcd_front_chk.sv
`timescale 1ns/1ps
module lcd_front_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // host side
  input wire logic        chip_sel_n_i,
  input wire logic        data_cmd_sel_i,
  input wire logic        read_strobe_n_i,
  input wire logic        cmd_valid_o,
  input wire logic        param_valid_o,
  input wire logic [2:0]  active_mode_o,
  input wire logic [17:0] parallel_bus_oe_o,
  // panel side
  input wire logic        vsync_oe_o,
  input wire logic        hsync_oe_o,
  input wire logic        pixel_valid_oe_o,
  input wire logic        tear_enable_i,
  input wire logic        tear_sync_out_o,
  input wire logic        backlight_on_i,
  input wire logic        backlight_enable_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire mddi = active_mode_o == 3'h4;
  wire sync_oe = vsync_oe_o || hsync_oe_o || pixel_valid_oe_o;
  sequence s_cs_idle;
    chip_sel_n_i [*6];
  endsequence
  sequence s_dcx_high;
    (!active_mode_o[2] && data_cmd_sel_i) [*8];
  endsequence
  a_cs_gates_xfer: assert property (s_cs_idle |-> !cmd_valid_o && !param_valid_o)
    else $error("transfer while deselected");
  a_data_no_cmd: assert property (s_dcx_high |-> !cmd_valid_o)
    else $error("command with select high");
  a_cmd_one_cycle: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too long");
  a_bus_released: assert property ((!mddi && (!data_cmd_sel_i || read_strobe_n_i)) [*6]
    |-> parallel_bus_oe_o == 18'h00000) else $error("bus driven");
  a_mddi_drives: assert property (mddi [*3] |-> parallel_bus_oe_o[17:9] == 9'h1ff && sync_oe)
    else $error("sub panel pins not driven");
  a_sync_undriven: assert property ((!mddi) [*3] |-> !sync_oe)
    else $error("sync pins driven");
  a_tear_off_low: assert property ((!tear_enable_i) [*2] |-> !tear_sync_out_o)
    else $error("tear sync high while off");
  a_backlight_follows: assert property ($changed(backlight_on_i)
    |-> ##[1:3] backlight_enable_out_o == backlight_on_i) else $error("backlight lag");
endmodule
bind lcd_host_interface_front_end lcd_front_chk u_lcd_front_chk (.*);

// ### verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic        clk_i,
  // host pins
  output logic             cs_n_o,
  output logic             dcx_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             sdi_o,
  output logic      [17:0] bus_o,
  // pins read back
  input  wire logic [17:0] bus_i,
  input  wire logic        sdo_i
);
  logic [17:0] rdata;
  logic [7:0]  sdata;
  initial {cs_n_o, dcx_o, rd_n_o, wr_n_o, sdi_o, bus_o} = {4'hf, 19'h00000};
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic cs, input logic dc, input logic [17:0] d);
    cs_n_o <= cs;
    dcx_o <= dc;
    bus_o <= d;
    cyc(4);
    wr_n_o <= 1'b0;
    cyc(4);
    wr_n_o <= 1'b1;
    cyc(4);
    cs_n_o <= 1'b1;
    cyc(2);
  endtask
  task automatic rd(input logic dc);
    cs_n_o <= 1'b0;
    dcx_o <= dc;
    bus_o <= ~bus_o;
    cyc(4);
    rd_n_o <= 1'b0;
    cyc(7);
    rdata = bus_i;
    rd_n_o <= 1'b1;
    cyc(4);
    cs_n_o <= 1'b1;
    cyc(2);
  endtask
  task automatic sel(input logic v);
    cs_n_o <= v;
    cyc(4);
  endtask
  task automatic sw(input logic dc, input logic [7:0] d);
    dcx_o <= dc;
    for (int i = 7; i >= 0; i--)
    begin
      wr_n_o <= 1'b0;
      sdi_o <= d[i];
      cyc(4);
      wr_n_o <= 1'b1;
      cyc(4);
      sdata[i] = sdo_i;
    end
  endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t got %h expected %h", $time, a, b); end end
module testbench;
  logic clk_i, reset_n_i, serial_in_i, pixel_clk_i, vsync_i, hsync_i, pixel_valid_i;
  logic chip_sel_n_i, data_cmd_sel_i, read_strobe_n_i, write_strobe_n_i, serial_out_o;
  logic vsync_o, vsync_oe_o, sub_panel_regsel_o, hsync_oe_o, pixel_valid_o, pixel_valid_oe_o;
  logic tear_sync_out_o, backlight_pwm_o, backlight_enable_out_o, vcom_polarity_o, p;
  logic cmd_valid_o, param_valid_o, ram_write_mode_i, ram_read_mode_i, addr_set_i;
  logic addr_step_down_i, video_mode_i, tear_enable_i, frame_blank_i, backlight_on_i;
  logic vcom_run_i, trim_prog_i, reduced_color_i, sub_cs_n_i, sub_regsel_i, sub_wr_n_i;
  logic [2:0] iface_mode_pins_i, active_mode_o;
  logic [6:0] vcom_trim_o, trim_data_i;
  logic [7:0] xfer_byte_o, param_rd_i, pwm_duty_i, vcom_period_i;
  logic [8:0] sub_bus_i;
  logic [16:0] disp_addr_i;
  logic [17:0] hbus, parallel_bus_o, parallel_bus_oe_o, disp_pixel_o;
  lcd_front_pkg::window_t win_i;
  wire [17:0] parallel_bus_i = (parallel_bus_o & parallel_bus_oe_o) | (hbus & ~parallel_bus_oe_o);
  int checked, miscompares, hi;
  logic [7:0] duty [3] = '{8'h00, 8'h80, 8'hff};
  lcd_host_interface_front_end u_lcd_host_interface_front_end (.*);
  host_model u_host_model (.clk_i, .cs_n_o(chip_sel_n_i), .dcx_o(data_cmd_sel_i),
    .rd_n_o(read_strobe_n_i), .wr_n_o(write_strobe_n_i), .sdi_o(serial_in_i),
    .bus_o(hbus), .bus_i(parallel_bus_i), .sdo_i(serial_out_o));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic boot(input logic [2:0] m);
    reset_n_i <= 1'b0;
    iface_mode_pins_i <= m;
    cyc(20);
    reset_n_i <= 1'b1;
    cyc(6);
    `CHK(active_mode_o, m)
  endtask
  task automatic xfer(input logic cs, dc, input logic [7:0] d, input logic [1:0] e);
    logic [1:0] got;
    got = 2'b00;
    fork
      u_host_model.wr(cs, dc, {10'h000, d});
      repeat (20) @(posedge clk_i) got |= {cmd_valid_o, param_valid_o};
    join
    `CHK(got, e)
    if (e != 2'b00)
      `CHK(xfer_byte_o, d)
  endtask
  task automatic pix(input logic [5:0] r, g, b);
    u_host_model.wr(1'b0, 1'b1, {10'h000, r, 2'b00});
    u_host_model.wr(1'b0, 1'b1, {10'h000, g, 2'b00});
    u_host_model.wr(1'b0, 1'b1, {10'h000, b, 2'b00});
  endtask
  task automatic peek(input int a, input logic [17:0] e);
    disp_addr_i <= a[16:0];
    cyc(3);
    `CHK(disp_pixel_o, e)
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial
  begin
    {pixel_clk_i, hsync_i, pixel_valid_i, ram_write_mode_i, ram_read_mode_i, addr_set_i,
      addr_step_down_i, video_mode_i, tear_enable_i, frame_blank_i, backlight_on_i, vcom_run_i,
      trim_prog_i, reduced_color_i, sub_regsel_i, trim_data_i, param_rd_i, pwm_duty_i,
      vcom_period_i, sub_bus_i, disp_addr_i, win_i} = '0;
    {sub_cs_n_i, sub_wr_n_i, vsync_i, reset_n_i, iface_mode_pins_i} = 7'h73;
    boot(3'h3);
    iface_mode_pins_i <= 3'h0;
    xfer(1'b0, 1'b0, 8'h2c, 2'b10);
    `CHK(active_mode_o, 3'h3)
    xfer(1'b0, 1'b1, 8'h5a, 2'b01);
    xfer(1'b1, 1'b0, 8'h11, 2'b00);
    param_rd_i <= 8'h96;
    u_host_model.rd(1'b0);
    `CHK(u_host_model.rdata[7:0], 8'hee)
    u_host_model.rd(1'b1);
    `CHK(u_host_model.rdata[7:0], 8'h96)
    $display("host tests done");
    win_i <= {8'h03, 8'h04, 9'h002, 9'h003};
    ram_write_mode_i <= 1'b1;
    xfer(1'b0, 1'b0, 8'h2c, 2'b10);
    addr_set_i <= 1'b1;
    cyc(1);
    addr_set_i <= 1'b0;
    pix(6'h21, 6'h0c, 6'h3f);
    pix(6'h05, 6'h22, 6'h10);
    pix(6'h3a, 6'h01, 6'h2b);
    cyc(6);
    peek(483, {6'h21, 6'h0c, 6'h3f});
    peek(484, {6'h05, 6'h22, 6'h10});
    peek(723, {6'h3a, 6'h01, 6'h2b});
    reduced_color_i <= 1'b1;
    peek(723, {6'h3f, 6'h00, 6'h3f});
    ram_read_mode_i <= 1'b1;
    addr_set_i <= 1'b1;
    cyc(1);
    addr_set_i <= 1'b0;
    u_host_model.rd(1'b1);
    u_host_model.rd(1'b1);
    `CHK(u_host_model.rdata[8:0], 9'h13f)
    video_mode_i <= 1'b1;
    vsync_i <= 1'b0;
    pixel_valid_i <= 1'b1;
    u_host_model.bus_o <= 18'h2a5a5;
    cyc(4);
    vsync_i <= 1'b1;
    cyc(4);
    pixel_clk_i <= 1'b1;
    cyc(4);
    pixel_clk_i <= 1'b0;
    cyc(4);
    reduced_color_i <= 1'b0;
    peek(0, 18'h2a5a5);
    $display("memory tests done");
    frame_blank_i <= 1'b1;
    backlight_on_i <= 1'b1;
    cyc(4);
    `CHK(tear_sync_out_o, 1'b0)
    `CHK(backlight_enable_out_o, 1'b1)
    tear_enable_i <= 1'b1;
    trim_data_i <= 7'h55;
    trim_prog_i <= 1'b1;
    cyc(4);
    `CHK(tear_sync_out_o, 1'b1)
    trim_prog_i <= 1'b0;
    trim_data_i <= 7'h2a;
    cyc(2);
    trim_prog_i <= 1'b1;
    cyc(2);
    `CHK(vcom_trim_o, 7'h55)
    vcom_period_i <= 8'h01;
    vcom_run_i <= 1'b1;
    cyc(2100);
    p = vcom_polarity_o;
    cyc(2000);
    `CHK(vcom_polarity_o, ~p)
    vcom_run_i <= 1'b0;
    cyc(2);
    p = vcom_polarity_o;
    cyc(4100);
    `CHK(vcom_polarity_o, p)
    $display("panel tests done");
    foreach (duty[i])
    begin
      pwm_duty_i <= duty[i];
      cyc(4);
      hi = 0;
      repeat (12750) @(posedge clk_i) hi += backlight_pwm_o;
      `CHK(hi, 50 * duty[i])
    end
    $display("backlight tests done");
    boot(3'h4);
    sub_cs_n_i <= 1'b0;
    sub_regsel_i <= 1'b1;
    sub_wr_n_i <= 1'b0;
    sub_bus_i <= 9'h1a5;
    xfer(1'b0, 1'b0, 8'h2c, 2'b00);
    `CHK({vsync_o, sub_panel_regsel_o, pixel_valid_o, parallel_bus_o[17:9]}, 12'h5a5)
    boot(3'h7);
    param_rd_i <= 8'hc3;
    u_host_model.sel(1'b0);
    u_host_model.sw(1'b0, 8'hda);
    cyc(6);
    `CHK(xfer_byte_o, 8'hda)
    u_host_model.sw(1'b1, 8'h00);
    `CHK(u_host_model.sdata, 8'hc3)
    u_host_model.sel(1'b1);
    for (int m = 0; m < 8; m++)
      boot(m[2:0]);
    $display("mode tests done");
    complete_run;
  end
endmodule
